// >>> scaler_defines.vh
// Constants for the analog and pulse reference scaler.
// Assumes one 20 MHz clock; included by the scaler and filter modules.
`ifndef SCALER_DEFINES_VH
`define SCALER_DEFINES_VH
`define CLK_HZ 20000000
`define MS_CYCLES (`CLK_HZ / 1000)
`define TC_MS_DEFAULT 16'h000A
`define TC_MS_MAX 16'h270F
// Source selection codes
`define SRC_VOLT 3'h0
`define SRC_VOLT_SIGNED 3'h1
`define SRC_CURR 3'h2
`define SRC_VOLT_CURR 3'h3
`define SRC_PULSE 3'h4
// Voltage points in 10 mV steps, current in 10 uA, pulse in Hz
`define VOLT_LOW_DEF 16'h0000
`define VOLT_HIGH_DEF 16'h03E8
`define VOLT_MAX 16'h04B0
`define CURR_LOW_DEF 16'h0190
`define CURR_HIGH_DEF 16'h07D0
`define CURR_MAX 16'h07D0
`define PULSE_LOW_DEF 17'h00000
`define PULSE_HIGH_DEF 17'h02710
`define PULSE_LOW_MAX 17'h02710
`define PULSE_HIGH_MIN 17'h02710
`define PULSE_HIGH_MAX 17'h186A0
// Reference points in 0.01 Hz or 0.01 unit
`define REF_LOW_DEF 16'h0000
`define REF_HIGH_DEF 16'h1770
`define TARGET_MAX 16'h2710
`define GATE_CYCLES 25'h1312D00
`endif

// >>> lowpass_filter.v
// First-order low-pass filter with a time constant in milliseconds.
// Assumes sample values on the same clock as the filter.
`timescale 1ns/100ps
`include "scaler_defines.vh"
module lowpass_filter #(
  parameter WIDTH = 17
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Millisecond tick and setting
  input wire ms_tick,
  input wire [15:0] time_const_ms,
  // Data
  input wire [WIDTH-1:0] sample,
  output reg [WIDTH-1:0] filtered
);
  // Accumulator holds 16 fraction bits so small steps are not lost
  reg [WIDTH+15:0] acc;
  wire [WIDTH+15:0] target = {sample, 16'h0000};
  wire [15:0] div = time_const_ms + 16'h0001;
  wire [WIDTH+15:0] step_up = (target - acc) / {{WIDTH{1'b0}}, div};
  wire [WIDTH+15:0] step_dn = (acc - target) / {{WIDTH{1'b0}}, div};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= {(WIDTH+16){1'b0}};
      filtered <= {WIDTH{1'b0}};
    end else begin
      if (time_const_ms == 16'h0000) begin
        acc <= target;
      end else if (ms_tick) begin
        // Larger constant means smaller step and slower response
        if (target >= acc) begin
          acc <= acc + step_up;
        end else begin
          acc <= acc - step_dn;
        end
      end
      filtered <= acc[WIDTH+15:16];
    end
  end
endmodule // lowpass_filter

// >>> analog_pulse_reference_scaler.v
// Reference scaler: filters and maps voltage, current or pulse input.
// Assumes digitised analog codes on clk; pulse pins are asynchronous.
// What this block does
// - Voltage scaling only for voltage source selections
// - Voltage filter 0 to 9999 ms, default 10
// - Lower voltage point 0-12 V, default 0
// - Upper voltage point default 10 V, 60 Hz
// - Points are frequency, or 0-100.00 target
// - Current scaling only for current selections
// - Current filter constant, default 10 ms
// - Current points 0-20 mA, default 4/20
// - Pulse command only when pulse source chosen
// - Pulse method first pin or both pins
// - Pulse filter 0 to 9999 ms, default 10
// - Lower pulse point 0-10 kHz, default 0
// - Upper pulse point 10-100 kHz, default 10
`timescale 1ns/100ps
`include "scaler_defines.vh"
module analog_pulse_reference_scaler #(
  parameter GATE_CYCLES = `GATE_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Source selection and modes
  input wire [2:0] source_select,
  input wire pulse_both_inputs,
  input wire process_control,
  input wire [15:0] max_frequency,
  // Voltage settings
  input wire [15:0] voltage_filter_ms,
  input wire [15:0] voltage_low_point,
  input wire [15:0] voltage_high_point,
  input wire [15:0] voltage_low_ref,
  input wire [15:0] voltage_high_ref,
  // Current settings
  input wire [15:0] current_filter_ms,
  input wire [15:0] current_low_point,
  input wire [15:0] current_high_point,
  input wire [15:0] current_low_ref,
  input wire [15:0] current_high_ref,
  // Pulse settings
  input wire [15:0] pulse_filter_ms,
  input wire [16:0] pulse_rate_low_point,
  input wire [16:0] pulse_rate_high_point,
  input wire [15:0] pulse_low_ref,
  input wire [15:0] pulse_high_ref,
  // Inputs
  input wire [15:0] voltage_input,
  input wire [15:0] current_input,
  input wire pulse_input_first,
  input wire pulse_input_second,
  // Result
  output reg [15:0] reference,
  output reg reference_valid
);
  // Pulse pins pass two flops before any logic
  reg [1:0] sync_a;
  reg [1:0] sync_b;
  reg prev_a;
  reg prev_b;
  reg [24:0] gate_cnt;
  reg [16:0] pulse_cnt;
  reg [16:0] pulse_rate;
  reg [14:0] ms_cnt;
  reg ms_tick;
  wire [16:0] volt_f;
  wire [16:0] curr_f;
  wire [16:0] pulse_f;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 2'h0;
      sync_b <= 2'h0;
      prev_a <= 1'b0;
      prev_b <= 1'b0;
    end else begin
      sync_a <= {sync_a[0], pulse_input_first};
      sync_b <= {sync_b[0], pulse_input_second};
      prev_a <= sync_a[1];
      prev_b <= sync_b[1];
    end
  end

  wire rise_a = sync_a[1] & ~prev_a;
  wire rise_b = sync_b[1] & ~prev_b;
  // Single mode ignores the second pin; a source on both would be lost
  wire count_b = pulse_both_inputs & rise_b;
  wire [1:0] add_cnt = {1'b0, rise_a} + {1'b0, count_b};
  wire [17:0] cnt_sum = {1'b0, pulse_cnt} + {16'h0000, add_cnt};
  // Both pins at full rate overflow 17 bits; hold at all ones instead
  wire [16:0] cnt_next = cnt_sum[17] ? 17'h1FFFF : cnt_sum[16:0];

  // One-second gate gives the rate directly in Hz
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_cnt <= 25'h0000000;
      pulse_cnt <= 17'h00000;
      pulse_rate <= 17'h00000;
    end else if (gate_cnt == GATE_CYCLES[24:0] - 25'h0000001) begin
      gate_cnt <= 25'h0000000;
      pulse_rate <= cnt_next;
      pulse_cnt <= 17'h00000;
    end else begin
      gate_cnt <= gate_cnt + 25'h0000001;
      pulse_cnt <= cnt_next;
    end
  end

  // Millisecond tick shared by all three filters
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt <= 15'h0000;
      ms_tick <= 1'b0;
    end else if (ms_cnt == `MS_CYCLES - 1) begin
      ms_cnt <= 15'h0000;
      ms_tick <= 1'b1;
    end else begin
      ms_cnt <= ms_cnt + 15'h0001;
      ms_tick <= 1'b0;
    end
  end

  // Constants above the documented ceiling are held at it
  function [15:0] lim_tc;
    input [15:0] tc;
    begin
      lim_tc = (tc > `TC_MS_MAX) ? `TC_MS_MAX : tc;
    end
  endfunction

  lowpass_filter #(.WIDTH(17)) u_volt_filter (
    .clk(clk),
    .rst_n(rst_n),
    .ms_tick(ms_tick),
    .time_const_ms(lim_tc(voltage_filter_ms)),
    .sample({1'b0, voltage_input}),
    .filtered(volt_f)
  );

  lowpass_filter #(.WIDTH(17)) u_curr_filter (
    .clk(clk),
    .rst_n(rst_n),
    .ms_tick(ms_tick),
    .time_const_ms(lim_tc(current_filter_ms)),
    .sample({1'b0, current_input}),
    .filtered(curr_f)
  );

  lowpass_filter #(.WIDTH(17)) u_pulse_filter (
    .clk(clk),
    .rst_n(rst_n),
    .ms_tick(ms_tick),
    .time_const_ms(lim_tc(pulse_filter_ms)),
    .sample(pulse_rate),
    .filtered(pulse_f)
  );

  // Breakpoints held inside their settable ranges
  wire [15:0] v_lo = (voltage_low_point > `VOLT_MAX) ?
    `VOLT_MAX : voltage_low_point;
  wire [15:0] v_hi = (voltage_high_point > `VOLT_MAX) ?
    `VOLT_MAX : voltage_high_point;
  wire [15:0] c_lo = (current_low_point > `CURR_MAX) ?
    `CURR_MAX : current_low_point;
  wire [15:0] c_hi = (current_high_point > `CURR_MAX) ?
    `CURR_MAX : current_high_point;
  wire [16:0] p_lo = (pulse_rate_low_point > `PULSE_LOW_MAX) ?
    `PULSE_LOW_MAX : pulse_rate_low_point;
  wire [16:0] p_hi = (pulse_rate_high_point < `PULSE_HIGH_MIN) ?
    `PULSE_HIGH_MIN : (pulse_rate_high_point > `PULSE_HIGH_MAX) ?
    `PULSE_HIGH_MAX : pulse_rate_high_point;

  // Reference points capped at max frequency or at 100.00
  wire [15:0] ref_cap = process_control ? `TARGET_MAX : max_frequency;
  function [15:0] cap;
    input [15:0] val;
    input [15:0] top;
    begin
      cap = (val > top) ? top : val;
    end
  endfunction

  // Two-point line; equal breakpoints fall back to the lower point
  function [15:0] interp;
    input [16:0] x;
    input [16:0] x1;
    input [16:0] x2;
    input [15:0] y1;
    input [15:0] y2;
    reg [33:0] span;
    reg [16:0] dx;
    reg [16:0] rng;
    begin
      span = 34'h000000000;
      dx = 17'h00000;
      rng = 17'h00000;
      if (x2 <= x1 || x <= x1) begin
        interp = y1;
      end else if (x >= x2) begin
        interp = y2;
      end else begin
        dx = x - x1;
        rng = x2 - x1;
        if (y2 >= y1) begin
          span = ({18'h00000, y2 - y1} * {17'h00000, dx}) /
            {17'h00000, rng};
          interp = y1 + span[15:0];
        end else begin
          span = ({18'h00000, y1 - y2} * {17'h00000, dx}) /
            {17'h00000, rng};
          interp = y1 - span[15:0];
        end
      end
    end
  endfunction

  wire [15:0] volt_ref = interp(volt_f, {1'b0, v_lo}, {1'b0, v_hi},
    cap(voltage_low_ref, ref_cap), cap(voltage_high_ref, ref_cap));
  wire [15:0] curr_ref = interp(curr_f, {1'b0, c_lo}, {1'b0, c_hi},
    cap(current_low_ref, ref_cap), cap(current_high_ref, ref_cap));
  wire [15:0] pulse_ref = interp(pulse_f, p_lo, p_hi,
    cap(pulse_low_ref, ref_cap), cap(pulse_high_ref, ref_cap));

  // Combined mode: voltage is the main reference, current adds to it
  wire [16:0] sum_ref = {1'b0, volt_ref} + {1'b0, curr_ref};
  wire [15:0] sum_cap = (sum_ref > {1'b0, ref_cap}) ?
    ref_cap : sum_ref[15:0];

  reg [15:0] next_reference;
  reg next_valid;
  always @* begin
    next_reference = 16'h0000;
    next_valid = 1'b1;
    case (source_select)
      `SRC_VOLT, `SRC_VOLT_SIGNED: begin
        next_reference = volt_ref;
      end
      `SRC_CURR: begin
        next_reference = curr_ref;
      end
      `SRC_VOLT_CURR: begin
        next_reference = sum_cap;
      end
      `SRC_PULSE: begin
        next_reference = pulse_ref;
      end
      default: begin
        next_valid = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reference <= 16'h0000;
      reference_valid <= 1'b0;
    end else begin
      reference <= next_reference;
      reference_valid <= next_valid;
    end
  end
endmodule // analog_pulse_reference_scaler

// >>> analog_pulse_reference_scaler_properties.sv
// Checker bound to the reference scaler ports.
// Assumes exact maps only with zero filter and settings held still.
`timescale 1ns/100ps
module analog_pulse_reference_scaler_properties #(
  parameter GATE_CYCLES = 20000000
) (
  input wire clk, rst_n, pulse_both_inputs, process_control,
  input wire [2:0] source_select,
  input wire [15:0] max_frequency, voltage_filter_ms, voltage_low_point,
  input wire [15:0] voltage_high_point, voltage_low_ref, voltage_high_ref,
  input wire [15:0] current_filter_ms, current_low_point, current_high_point,
  input wire [15:0] current_low_ref, current_high_ref, pulse_filter_ms,
  input wire [16:0] pulse_rate_low_point, pulse_rate_high_point,
  input wire [15:0] pulse_low_ref, pulse_high_ref, voltage_input,
  input wire [15:0] current_input,
  input wire pulse_input_first, pulse_input_second,
  input wire [15:0] reference,
  input wire reference_valid
);
  // Pulse settings other than pulse_both_inputs left out: the analog paths never look at them
  wire [212:0] all_in = {source_select, process_control, pulse_both_inputs,
    max_frequency, voltage_filter_ms, voltage_low_point, voltage_high_point,
    voltage_low_ref, voltage_high_ref, current_filter_ms, current_low_point,
    current_high_point, current_low_ref, current_high_ref, voltage_input,
    current_input};
  wire plain = !process_control && max_frequency == 16'hFFFF;
  wire vsel = source_select == 3'h0 && voltage_filter_ms == 16'h0000 && plain;
  wire vdef = vsel && voltage_low_point == 16'h0000 &&
    voltage_high_point == 16'h03E8 && voltage_low_ref == 16'h0000 &&
    voltage_high_ref == 16'h1770;
  wire cdef = source_select == 3'h2 && current_filter_ms == 16'h0000 &&
    plain && current_low_point == 16'h0190 && current_high_point == 16'h07D0
    && current_low_ref == 16'h0000 && current_high_ref == 16'h1770;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_volt_map;
    ($stable(all_in) && vdef) [*5] |-> reference ==
      (voltage_input >= 16'h03E8 ? 16'h1770 : voltage_input * 16'h0006);
  endproperty
  a_volt_map: assert property (p_volt_map)
    else $error("voltage map");
  property p_curr_map;
    ($stable(all_in) && cdef) [*5] |-> reference ==
      (current_input <= 16'h0190 ? 16'h0000 :
       current_input >= 16'h07D0 ? 16'h1770 :
       ((current_input - 16'h0190) * 16'h000F) >> 2);
  endproperty
  a_curr_map: assert property (p_curr_map)
    else $error("current map");
  property p_low_clamp;
    ($stable(all_in) && vsel && voltage_low_point <= 16'h04B0 &&
      voltage_input <= voltage_low_point) [*5] |->
      reference == voltage_low_ref;
  endproperty
  a_low_clamp: assert property (p_low_clamp)
    else $error("low clamp");
  property p_high_clamp;
    ($stable(all_in) && vsel && voltage_high_point <= 16'h04B0 &&
      voltage_high_point > voltage_low_point &&
      voltage_input >= voltage_high_point) [*5] |->
      reference == voltage_high_ref;
  endproperty
  a_high_clamp: assert property (p_high_clamp)
    else $error("high clamp");
  property p_proc_cap;
    ($stable(all_in) && process_control) [*5] |-> reference <= 16'h2710;
  endproperty
  a_proc_cap: assert property (p_proc_cap)
    else $error("target cap");
  property p_freq_cap;
    ($stable(all_in) && !process_control) [*5] |->
      reference <= max_frequency;
  endproperty
  a_freq_cap: assert property (p_freq_cap)
    else $error("frequency cap");
  property p_valid_on;
    source_select <= 3'h4 |=> reference_valid;
  endproperty
  a_valid_on: assert property (p_valid_on)
    else $error("valid low");
  property p_valid_off;
    source_select > 3'h4 |=> !reference_valid;
  endproperty
  a_valid_off: assert property (p_valid_off)
    else $error("valid high");
  c_volt: cover property (vdef [*5]);
  c_pulse: cover property (source_select == 3'h4 && reference > 16'h0BB0);
  c_target: cover property (process_control && reference == 16'h2710);
endmodule // analog_pulse_reference_scaler_properties

bind analog_pulse_reference_scaler analog_pulse_reference_scaler_properties
  #(.GATE_CYCLES(GATE_CYCLES)) u_props (.*);

// >>> pulse_source_model.sv
// Open-collector pulse source feeding the two pulse pins.
// Assumes a pull-down: pins rest low while disabled.
`timescale 1ns/100ps
module pulse_source_model #(
  parameter HALF_NS = 100
) (
  input wire enable,
  input wire both_pins,
  output reg pin_first,
  output reg pin_second
);
  initial begin
    pin_first = 1'b0;
    forever #(HALF_NS) pin_first = enable ? ~pin_first : 1'b0;
  end
  // Second pin offset by a quarter period so edges never coincide
  initial begin
    pin_second = 1'b0;
    #(HALF_NS / 2);
    forever #(HALF_NS)
      pin_second = (enable && both_pins) ? ~pin_second : 1'b0;
  end
endmodule // pulse_source_model

// >>> analog_pulse_reference_scaler_tb.sv
// Self-checking bench for the reference scaler.
// Assumes 20 MHz clock, pulse gate shortened to 2000 cycles.
`timescale 1ns/100ps
module analog_pulse_reference_scaler_tb;
  localparam GATE = 2000;
  reg clk = 1'b0, rst_n = 1'b0, pulse_on = 1'b0;
  reg pulse_both_inputs = 1'b0, process_control = 1'b0;
  reg [2:0] source_select = 3'h0;
  reg [15:0] max_frequency = 16'hFFFF, voltage_filter_ms = 16'h0000;
  reg [15:0] voltage_low_point = 16'h0000, voltage_high_point = 16'h03E8;
  reg [15:0] voltage_low_ref = 16'h0000, voltage_high_ref = 16'h1770;
  reg [15:0] current_filter_ms = 16'h0000, current_low_point = 16'h0190;
  reg [15:0] current_high_point = 16'h07D0, current_low_ref = 16'h0000;
  reg [15:0] current_high_ref = 16'h1770, pulse_filter_ms = 16'h0000;
  reg [16:0] pulse_rate_low_point = 17'h00000;
  reg [16:0] pulse_rate_high_point = 17'h02710;
  reg [15:0] pulse_low_ref = 16'h0000, pulse_high_ref = 16'hEA60;
  reg [15:0] voltage_input = 16'h0000, current_input = 16'h0000;
  wire pulse_input_first, pulse_input_second, reference_valid;
  wire [15:0] reference;
  integer miscompares = 0, num_checks = 0, i, e;
  always #25 clk = ~clk;
  analog_pulse_reference_scaler #(.GATE_CYCLES(GATE)) u_dut (.*);
  pulse_source_model u_src (.enable(pulse_on), .both_pins(pulse_both_inputs),
    .pin_first(pulse_input_first), .pin_second(pulse_input_second));
  function integer map(input integer x, x1, x2, y1, y2);
    if (x <= x1 || x2 <= x1) map = y1;
    else if (x >= x2) map = y2;
    else map = y1 + (x - x1) * (y2 - y1) / (x2 - x1);
  endfunction
  function integer cap(input integer v);
    e = process_control ? 10000 : max_frequency;
    cap = (v > e) ? e : v;
  endfunction
  function integer ev(input integer dummy);
    ev = map(voltage_input, voltage_low_point, voltage_high_point,
      cap(voltage_low_ref), cap(voltage_high_ref));
  endfunction
  function integer ec(input integer dummy);
    ec = map(current_input, 400, 2000, 0, cap(6000));
  endfunction
  task step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task check_ref(input integer exp, input integer tol);
    num_checks = num_checks + 1;
    if (^reference === 1'bx || reference > exp + tol || reference + tol < exp)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, reference, exp);
    end
  endtask
  task check_valid(input exp);
    num_checks = num_checks + 1;
    if (reference_valid !== exp) begin
      miscompares = miscompares + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, reference_valid, exp);
    end
  endtask
  task finish_test;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #(60000 * 50);
    miscompares = miscompares + 1;
    finish_test;
  end
  initial begin
    e = $urandom(11);
    step(2);
    check_ref(0, 0);
    check_valid(1'b0);
    step(6);
    rst_n = 1'b1;
    // Defaults first, then random breakpoints, caps and combined source
    for (i = 0; i < 48; i = i + 1) begin
      source_select = (i < 16) ? 3'h0 : (i < 32) ? 3'h2 : 3'h3;
      process_control = (i % 8 == 7);
      max_frequency = (i >= 40) ? 16'h1B58 : 16'hFFFF;
      voltage_input = $urandom % 1300;
      current_input = $urandom % 2100;
      if (i >= 8) begin
        voltage_low_point = $urandom % 500;
        voltage_high_point = voltage_low_point + 1 + $urandom % 600;
        voltage_low_ref = $urandom % 9000;
        voltage_high_ref = voltage_low_ref + $urandom % 20000;
      end
      step(6);
      if (source_select == 3'h2) e = ec(0);
      else if (source_select == 3'h3) e = cap(ev(0) + ec(0));
      else e = ev(0);
      check_ref(e, 1);
    end
    for (i = 0; i < 8; i = i + 1) begin
      source_select = i[2:0];
      step(2);
      check_valid(i < 5);
    end
    process_control = 1'b0;
    max_frequency = 16'hFFFF;
    source_select = 3'h4;
    pulse_on = 1'b1;
    // 500 pulses a gate per pin, mapped 0..10000 onto 0..60000
    for (i = 0; i < 2; i = i + 1) begin
      pulse_both_inputs = i[0];
      step(3 * GATE);
      check_ref(3000 * (i + 1), 12);
    end
    pulse_on = 1'b0;
    source_select = 3'h0;
    voltage_low_point = 16'h0000;
    voltage_high_point = 16'h03E8;
    voltage_low_ref = 16'h0000;
    voltage_high_ref = 16'h1770;
    voltage_input = 16'h0000;
    current_input = 16'h0190;
    step(6);
    // One ms tick halves the gap, so the step must not land at once
    voltage_filter_ms = 16'h0001;
    voltage_input = 16'h03E8;
    current_filter_ms = 16'h0001;
    current_input = 16'h07D0;
    step(100);
    check_ref(1500, 1500);
    step(25000);
    check_ref(3750, 800);
    // Current path had the same single tick: halfway from 4 mA to 20 mA
    source_select = 3'h2;
    step(3);
    check_ref(3000, 1);
    finish_test;
  end
endmodule // analog_pulse_reference_scaler_tb
